// ===== logic/iebk_defs.vh
// Constants for the interrupt enable bank: map, field layout, reset values.
`ifndef IEBK_DEFS_VH
`define IEBK_DEFS_VH

// ****************************************
// Bus geometry
// ****************************************
`define IEBK_ADDR_W 8
`define IEBK_DATA_W 32
`define IEBK_NUM_SRC 48
`define IEBK_WORDS 3
`define IEBK_PRIO_W 3
`define IEBK_PRIO_WORDS 12

// ****************************************
// Register byte offsets
// ****************************************
`define IEBK_EN_BASE 8'h00
`define IEBK_FLAG_BASE 8'h10
`define IEBK_PRIO_BASE 8'h20
`define IEBK_STAT_OFF 8'h50

// ****************************************
// Decoded register classes
// ****************************************
`define IEBK_CLS_NONE 2'h0
`define IEBK_CLS_EN 2'h1
`define IEBK_CLS_FLAG 2'h2
`define IEBK_CLS_PRIO 2'h3
`define IEBK_SUB_STAT 4'hc

// ****************************************
// Implemented bit masks of the three words
// ****************************************
`define IEBK_IMPL_W0 16'h3fef
`define IEBK_IMPL_W1 16'hfedf
`define IEBK_IMPL_W2 16'h3fe3
`define IEBK_IMPL_ALL {`IEBK_IMPL_W2, `IEBK_IMPL_W1, `IEBK_IMPL_W0}

// ****************************************
// Enable bit positions, word 0
// ****************************************
`define IEBK_ADC_DONE_EN 13
`define IEBK_UART_A_TX_EN 12
`define IEBK_UART_A_RX_EN 11
`define IEBK_SPI_A_DONE_EN 10
`define IEBK_SPI_A_FAULT_EN 9
`define IEBK_TIMER_C_EN 8
`define IEBK_TIMER_B_EN 7
`define IEBK_OUT_CMP_B_EN 6
`define IEBK_IN_CAP_B_EN 5
`define IEBK_TIMER_A_EN 3
`define IEBK_OUT_CMP_A_EN 2
`define IEBK_IN_CAP_A_EN 1
`define IEBK_EXT_IRQ_A_EN 0

// ****************************************
// Enable bit positions, word 1
// ****************************************
`define IEBK_UART_B_TX_EN 15
`define IEBK_UART_B_RX_EN 14
`define IEBK_EXT_IRQ_C_EN 13
`define IEBK_TIMER_E_EN 12
`define IEBK_TIMER_D_EN 11
`define IEBK_OUT_CMP_D_EN 10
`define IEBK_OUT_CMP_C_EN 9
`define IEBK_IN_CAP_H_EN 7
`define IEBK_IN_CAP_G_EN 6
`define IEBK_EXT_IRQ_B_EN 4
`define IEBK_PIN_CHANGE_EN 3
`define IEBK_COMPARATOR_EN 2
`define IEBK_I2C_A_MASTER_EN 1
`define IEBK_I2C_A_SLAVE_EN 0

// ****************************************
// Enable bit positions, word 2
// ****************************************
`define IEBK_PAR_MASTER_PORT_EN 13
`define IEBK_OUT_CMP_H_EN 12
`define IEBK_OUT_CMP_G_EN 11
`define IEBK_OUT_CMP_F_EN 10
`define IEBK_OUT_CMP_E_EN 9
`define IEBK_IN_CAP_F_EN 8
`define IEBK_IN_CAP_E_EN 7
`define IEBK_IN_CAP_D_EN 6
`define IEBK_IN_CAP_C_EN 5
`define IEBK_SPI_B_EVENT_EN 1
`define IEBK_SPI_B_FAULT_EN 0

// ****************************************
// Reset values and bus responses
// ****************************************
`define IEBK_EN_RESET 16'h0000
`define IEBK_FLAG_RESET 16'h0000
`define IEBK_PRIO_RESET 3'h4
`define IEBK_PRIO_OFF 3'h0
`define IEBK_RESP_OKAY 2'h0
`define IEBK_RESP_SLVERR 2'h2

`endif

// ===== logic/iebk_flag_word.v
// One 16-bit word of sticky interrupt flags, set by sources and by software.
`timescale 1ns/1ps
`include "iebk_defs.vh"

module iebk_flag_word #(
  parameter [15:0] IMPL_MASK = 16'hffff
) (
  input wire clk,
  input wire rst_n,
  input wire [15:0] srcEvent,
  input wire wrEn,
  input wire [15:0] wrData,
  input wire [15:0] wrLanes,
  output wire [15:0] flags
);

  reg [15:0] flag_r;
  reg [15:0] flag_nxt;

  // A source event in the same cycle as a software clear keeps the flag set.
  always @* begin
    flag_nxt = flag_r;
    if (wrEn) begin
      flag_nxt = (flag_r & ~wrLanes) | (wrData & wrLanes);
    end
    flag_nxt = (flag_nxt | srcEvent) & IMPL_MASK;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      flag_r <= `IEBK_FLAG_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;

endmodule // iebk_flag_word

// ===== logic/iebk_prio_gate.v
// Priority gating of enabled requests and choice of the winning source.
`timescale 1ns/1ps
`include "iebk_defs.vh"

module iebk_prio_gate (
  input wire [47:0] pending,
  input wire [143:0] prio,
  output reg [47:0] gated,
  output reg anyReq,
  output reg [2:0] bestLevel,
  output reg [5:0] bestIndex
);

  integer i;
  reg [2:0] p;

  // Strict comparison: on equal levels the lowest source index wins.
  always @* begin
    p = `IEBK_PRIO_OFF;
    gated = 48'h000000000000;
    anyReq = 1'b0;
    bestLevel = `IEBK_PRIO_OFF;
    bestIndex = 6'h00;
    for (i = 0; i < `IEBK_NUM_SRC; i = i + 1) begin
      p = prio[i*3 +: 3];
      gated[i] = pending[i] && (p != `IEBK_PRIO_OFF);
      if (gated[i] && (p > bestLevel)) begin
        anyReq = 1'b1;
        bestLevel = p;
        bestIndex = i[5:0];
      end
    end
  end

endmodule // iebk_prio_gate

// ===== logic/iebk_bank.v
// Interrupt enable bank with flags, priorities and an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "iebk_defs.vh"

module iebk_bank (
  input wire clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [47:0] srcEvent,
  output wire [47:0] srcReq,
  output wire cpuIrq,
  output wire [2:0] cpuLevel,
  output wire [5:0] cpuVector
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Returns {class, sub-index}; the low two address bits are ignored.
  function [5:0] decodeAddr;
    input [7:0] a;
    reg [7:0] w;
    reg [7:0] off;
    begin
      w = {a[7:2], 2'h0};
      off = 8'h00;
      decodeAddr = {`IEBK_CLS_NONE, 4'h0};
      if (w >= `IEBK_EN_BASE && w < `IEBK_EN_BASE + 8'h0c) begin
        off = w - `IEBK_EN_BASE;
        decodeAddr = {`IEBK_CLS_EN, off[5:2]};
      end else if (w >= `IEBK_FLAG_BASE && w < `IEBK_FLAG_BASE + 8'h0c) begin
        off = w - `IEBK_FLAG_BASE;
        decodeAddr = {`IEBK_CLS_FLAG, off[5:2]};
      end else if (w >= `IEBK_PRIO_BASE && w < `IEBK_PRIO_BASE + 8'h30) begin
        off = w - `IEBK_PRIO_BASE;
        decodeAddr = {`IEBK_CLS_PRIO, off[5:2]};
      end else if (w == `IEBK_STAT_OFF) begin
        decodeAddr = {`IEBK_CLS_PRIO, `IEBK_SUB_STAT};
      end
    end
  endfunction

  // Bit mask of the two low byte lanes, which carry every 16-bit register.
  function [15:0] laneMask;
    input [3:0] strb;
    begin
      laneMask = {{8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // ****************************************
  // Write channel capture
  // ****************************************
  reg awHeld_r;
  reg [7:0] awAddr_r;
  reg wHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg bValid_r;
  reg [1:0] bResp_r;
  wire doWrite;
  wire [5:0] wrDec;
  wire [1:0] wrCls;
  wire [3:0] wrSub;
  wire [15:0] wrLanes;

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign wrDec = decodeAddr(awAddr_r);
  assign wrCls = wrDec[5:4];
  assign wrSub = wrDec[3:0];
  assign wrLanes = laneMask(wStrb_r);

  always @(posedge clk) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= `IEBK_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= (wrCls == `IEBK_CLS_NONE) ? `IEBK_RESP_SLVERR : `IEBK_RESP_OKAY;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // ****************************************
  // Enable and priority registers
  // ****************************************
  reg [47:0] enable_r;
  reg [143:0] prio_r;
  integer k;
  integer j;
  wire [47:0] implAll;

  assign implAll = `IEBK_IMPL_ALL;

  // Enables and priorities are written here; flags live in their own words.
  always @(posedge clk) begin
    if (!rst_n) begin
      enable_r <= {`IEBK_EN_RESET, `IEBK_EN_RESET, `IEBK_EN_RESET};
      for (k = 0; k < `IEBK_NUM_SRC; k = k + 1) begin
        prio_r[k*3 +: 3] <= `IEBK_PRIO_RESET;
      end
    end else if (doWrite) begin
      for (k = 0; k < `IEBK_WORDS; k = k + 1) begin
        if (wrCls == `IEBK_CLS_EN && wrSub == k[3:0]) begin
          enable_r[k*16 +: 16] <= ((enable_r[k*16 +: 16] & ~wrLanes) |
            (wData_r[15:0] & wrLanes)) & implAll[k*16 +: 16];
        end
      end
      for (k = 0; k < `IEBK_PRIO_WORDS; k = k + 1) begin
        if (wrCls == `IEBK_CLS_PRIO && wrSub == k[3:0]) begin
          for (j = 0; j < 4; j = j + 1) begin
            if (wStrb_r[j/2]) begin
              prio_r[(k*4+j)*3 +: 3] <= wData_r[j*4 +: 3];
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Flag words
  // ****************************************

  // Sources drive srcEvent from logic on this clock, so no synchroniser is used.
  // External inputs only arrive here once software has mapped them to a pin.
  wire [47:0] flagAll;
  localparam [47:0] IMPL_ALL = `IEBK_IMPL_ALL;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gFlag
      iebk_flag_word #(
        .IMPL_MASK(IMPL_ALL[g*16 +: 16])
      ) uFlag (
        .clk(clk),
        .rst_n(rst_n),
        .srcEvent(srcEvent[g*16 +: 16]),
        .wrEn(doWrite && wrCls == `IEBK_CLS_FLAG && wrSub == g),
        .wrData(wData_r[15:0]),
        .wrLanes(wrLanes),
        .flags(flagAll[g*16 +: 16])
      );
    end
  endgenerate

  // ****************************************
  // Request gating towards the core
  // ****************************************
  wire [47:0] pending;
  wire [47:0] gated;
  wire anyReq;
  wire [2:0] bestLevel;
  wire [5:0] bestIndex;
  reg [47:0] srcReq_r;
  reg cpuIrq_r;
  reg [2:0] cpuLevel_r;
  reg [5:0] cpuVector_r;

  assign pending = flagAll & enable_r;

  iebk_prio_gate uGate (
    .pending(pending),
    .prio(prio_r),
    .gated(gated),
    .anyReq(anyReq),
    .bestLevel(bestLevel),
    .bestIndex(bestIndex)
  );

  // Registered so the core sees glitch-free requests, at one cycle of latency.
  always @(posedge clk) begin
    if (!rst_n) begin
      srcReq_r <= 48'h000000000000;
      cpuIrq_r <= 1'b0;
      cpuLevel_r <= `IEBK_PRIO_OFF;
      cpuVector_r <= 6'h00;
    end else begin
      srcReq_r <= gated;
      cpuIrq_r <= anyReq;
      cpuLevel_r <= bestLevel;
      cpuVector_r <= bestIndex;
    end
  end

  assign srcReq = srcReq_r;
  assign cpuIrq = cpuIrq_r;
  assign cpuLevel = cpuLevel_r;
  assign cpuVector = cpuVector_r;

  // ****************************************
  // Read channel
  // ****************************************
  reg rValid_r;
  reg [31:0] rData_r;
  reg [1:0] rResp_r;
  reg [31:0] rdNxt;
  reg [1:0] rdResp;
  wire [5:0] rdDec;
  integer m;

  assign s_axi_arready = !rValid_r;
  assign rdDec = decodeAddr(s_axi_araddr);

  // Bit positions follow the enable map; unimplemented bits are zero in storage.
  always @* begin
    rdNxt = 32'h00000000;
    rdResp = `IEBK_RESP_OKAY;
    case (rdDec[5:4])
      `IEBK_CLS_EN: begin
        for (m = 0; m < `IEBK_WORDS; m = m + 1) begin
          if (rdDec[3:0] == m[3:0]) begin
            rdNxt[15:0] = enable_r[m*16 +: 16];
          end
        end
      end
      `IEBK_CLS_FLAG: begin
        for (m = 0; m < `IEBK_WORDS; m = m + 1) begin
          if (rdDec[3:0] == m[3:0]) begin
            rdNxt[15:0] = flagAll[m*16 +: 16];
          end
        end
      end
      `IEBK_CLS_PRIO: begin
        if (rdDec[3:0] == `IEBK_SUB_STAT) begin
          rdNxt[9:0] = {cpuIrq_r, cpuLevel_r, cpuVector_r};
        end else begin
          for (m = 0; m < 4; m = m + 1) begin
            rdNxt[m*4 +: 3] = prio_r[(rdDec[3:0]*4 + m)*3 +: 3];
          end
        end
      end
      default: begin
        rdResp = `IEBK_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= `IEBK_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rData_r <= rdNxt;
      rResp_r <= rdResp;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

endmodule // iebk_bank

// ===== dv/iebk_src_model.sv
// Behavioural peripheral sources that raise one-cycle request pulses.
`timescale 1ns/1ps
module iebk_src_model (
  input wire clk,
  input wire rst_n,
  input wire [47:0] fire,
  output wire [47:0] srcEvent
);
  // ********
  // Sources
  // ********
  reg [47:0] pulse_r;
  // External inputs count as already routed to a pin, so their pulses arrive directly.
  always @(posedge clk) begin
    pulse_r <= rst_n ? fire : 48'h0;
  end
  assign srcEvent = pulse_r;
endmodule // iebk_src_model

// ===== dv/iebk_bank_monitor.sv
// Port-level assertions for the interrupt enable bank.
`timescale 1ns/1ps
`include "iebk_defs.vh"
module iebk_bank_monitor (
  input wire clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [47:0] srcReq,
  input wire cpuIrq,
  input wire [2:0] cpuLevel,
  input wire [5:0] cpuVector
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_irq_any_req: assert property (cpuIrq == (|srcReq))
    else $error("cpuIrq differs from srcReq");
  a_no_rsvd_req: assert property ((srcReq & ~`IEBK_IMPL_ALL) == 48'h0)
    else $error("request on unimplemented source");
  a_reset_quiet: assert property ($rose(rst_n) |-> srcReq == 48'h0 && !cpuIrq)
    else $error("request right after reset");
  a_idle_level: assert property (!cpuIrq |-> cpuLevel == 3'h0 && cpuVector == 6'h0)
    else $error("level or vector without request");
  a_winner_live: assert property (cpuIrq |-> cpuLevel != 3'h0 && srcReq[cpuVector])
    else $error("winner not requesting");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property (cpuIrq && cpuLevel == 3'h7);
  cover property (s_axi_bvalid && s_axi_bresp == `IEBK_RESP_SLVERR);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule // iebk_bank_monitor

bind iebk_bank iebk_bank_monitor iebk_bank_monitor_i (.clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .srcReq, .cpuIrq, .cpuLevel, .cpuVector);

// ===== dv/iebk_tb.sv
// Self-checking bench for the interrupt enable bank.
`timescale 1ns/1ps
`include "iebk_defs.vh"
module testbench;
  // ********
  // Harness
  // ********
  localparam [47:0] IMPL = {16'h3fe3, 16'hfedf, 16'h3fef};
  localparam [1:0] OK = `IEBK_RESP_OKAY;
  reg clk;
  reg rst_n = 1'b0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0, rv;
  reg [47:0] fire = 48'h0;
  reg [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpuIrq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [47:0] srcEvent, srcReq;
  wire [2:0] cpuLevel;
  wire [5:0] cpuVector;
  integer num_errors = 0, cmp_count = 0, cycles = 0, k, w;
  iebk_bank iebk_bank_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .srcEvent, .srcReq, .cpuIrq, .cpuLevel, .cpuVector);
  iebk_src_model iebk_src_model_i (.clk, .rst_n, .fire, .srcEvent);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  task wrap_up;
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input [47:0] seen, input [47:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // Outputs are looked at half a cycle after the edge that launches them.
  task tick(input integer n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task pulse(input integer n);
    @(posedge clk);
    fire <= 48'h1 << n;
    @(posedge clk);
    fire <= 48'h0;
  endtask
  // Handshakes are judged at the falling edge, where the levels equal those the next
  // rising edge samples; this keeps the bench out of the same-step race with the slave.
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg da, dw, ha, hw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      da = da | ha;
      dw = dw | hw;
    end
    do begin
      @(negedge clk);
      ha = s_axi_bvalid;
      @(posedge clk);
    end while (!ha);
    // The ready comes a cycle late on purpose, so the answer must hold.
    s_axi_bready <= 1'b1;
    @(negedge clk);
    rr = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    chk(rr, er);
  endtask
  task rd(input [7:0] a);
    reg h;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      h = s_axi_arready;
      @(posedge clk);
    end while (!h);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      h = s_axi_rvalid;
      @(posedge clk);
    end while (!h);
    // As on writes, the late ready makes the slave hold its answer for a cycle.
    s_axi_rready <= 1'b1;
    @(negedge clk);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // ********
  // Scenarios
  // ********
  task t_words;
    for (k = 0; k < 3; k = k + 1) begin
      rd(8'(4 * k));
      chk(rv, 0);
      wr(8'(4 * k), 32'hffffffff, OK);
      rd(8'(4 * k));
      chk(rv, IMPL[16 * k +: 16]);
      rd(8'(16 + 4 * k));
      chk(rv, 0);
      wr(8'(4 * k), 32'h0, OK);
    end
  endtask
  task t_each;
    reg [31:0] ev;
    for (k = 0; k < 48; k = k + 1) begin
      w = k / 16;
      ev = 32'((IMPL & (48'h1 << k)) >> (16 * w));
      pulse(k);
      tick(3);
      chk(srcReq, 0);
      wr(8'(4 * w), ev, OK);
      tick(3);
      chk(srcReq, IMPL & (48'h1 << k));
      chk(cpuVector, ev != 0 ? k : 0);
      wr(8'(4 * w), 32'h0, OK);
      tick(3);
      chk(srcReq, 0);
      rd(8'(16 + 4 * w));
      chk(rv, ev);
      wr(8'(16 + 4 * w), 32'h0, OK);
    end
  endtask
  task t_prio;
    wr(8'h00, 32'h1, OK);
    pulse(0);
    tick(3);
    chk({cpuIrq, cpuLevel}, 4'hc);
    wr(8'h20, 32'h0, OK);
    tick(3);
    chk(srcReq, 0);
    wr(8'h20, 32'h7, OK);
    tick(3);
    chk({cpuIrq, cpuLevel}, 4'hf);
    rd(8'h50);
    chk(rv, 32'h3c0);
    wr(8'h00, 32'h3, OK);
    wr(8'h20, 32'h47, OK);
    pulse(1);
    tick(3);
    chk(srcReq, 48'h3);
    chk({cpuLevel, cpuVector}, 9'h1c0);
    wr(8'h20, 32'h77, OK);
    tick(3);
    chk({cpuLevel, cpuVector}, 9'h1c0);
    wr(8'h20, 32'h74, OK);
    tick(3);
    chk({cpuLevel, cpuVector}, 9'h1c1);
    wr(8'h00, 32'h0, OK);
    wr(8'h10, 32'h0, OK);
    wr(8'h20, 32'h4444, OK);
  endtask
  task t_reset;
    wr(8'h04, 32'hffff, OK);
    wr(8'h20, 32'h0, OK);
    pulse(16);
    tick(3);
    chk(srcReq, 48'h1 << 16);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk(srcReq, 0);
    chk(cpuIrq, 0);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04);
    chk(rv, 0);
    rd(8'h14);
    chk(rv, 0);
    rd(8'h20);
    chk(rv, 32'h4444);
  endtask
  task t_bad;
    wr(8'h0c, 32'hffff, `IEBK_RESP_SLVERR);
    rd(8'h0c);
    chk(rr, `IEBK_RESP_SLVERR);
    chk(rv, 0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_words;
    t_each;
    t_prio;
    t_reset;
    t_bad;
    wrap_up;
  end
endmodule // testbench
